// File: sps_sequencer.sv
// Implementation choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "sps_defs.svh"
// Operation
// - Interrupt stop lands set distance past input
// - Stop point follows live position, not fixed
// - Skip interrupt step if prior move shorter
// - Short interrupt distance forces faster deceleration
// - Input wait holds until program input on
// - Pulse wait holds until count exceeds setting
// - Pulse wait of zero clears the count
// - Loop body repeats the loop-begin count
// - Repeat at start reruns program; otherwise once
// - Repeat value zero means endless
// - Direction digit flips position data sign
// - Forward start runs selected program; reverse ignored
// - Trip waits for address or distance passed
module sps_sequencer #(
  parameter int PROG_W = 3,
  parameter int STEP_W = 5,
  parameter int POS_W = 32
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic forward_start_input,
  input wire logic reverse_start_input,
  input wire logic [PROG_W-1:0] prog_select,
  input wire logic program_input_one,
  input wire logic mpg_pulse,
  input wire logic signed [POS_W-1:0] axis_pos,
  input wire logic [POS_W-1:0] axis_decel_dist,
  input wire logic axis_done,
  input wire logic axis_cmd_ready,
  output logic axis_cmd_valid,
  output logic [1:0] axis_cmd_kind,
  output logic signed [POS_W-1:0] axis_cmd_target,
  output logic axis_fast_decel,
  output logic prog_busy
);

  localparam int AW = PROG_W + STEP_W;

  // Registers and sequencing state
  logic [3:0] command_mode_param;
  logic [3:0] start_direction_param;
  logic [AW-1:0] load_addr;
  logic mode_err;
  logic [31:0] pulse_cnt;
  sps_pkg::sps_state_t state;
  logic [PROG_W-1:0] prog;
  logic [STEP_W-1:0] step;
  logic [STEP_W-1:0] loop_start;
  logic [27:0] loop_left;
  logic rep_en;
  logic rep_endless;
  logic [27:0] rep_left;
  logic signed [POS_W-1:0] arg;
  logic signed [POS_W-1:0] cmd_end;
  logic signed [POS_W-1:0] move_start;
  logic [POS_W-1:0] last_dist;
  logic last_neg;
  logic wait_done;
  logic start_q;
  logic pi1_q;
  logic mpg_q;
  logic signed [POS_W-1:0] pi1_pos;

  // Decode and helpers
  logic [31:0] rd_word;
  sps_pkg::sps_op_t cur_op;
  logic signed [POS_W-1:0] cur_val;
  logic signed [POS_W-1:0] ppos;
  logic dir_flip;
  logic start_rise;
  logic pi1_rise;
  logic pulse_rise;
  logic cnt_clr;
  logic wb_req;
  logic mem_we;

  function automatic logic signed [POS_W-1:0] flip(input logic signed [POS_W-1:0] v,
                                                    input logic f);
    flip = f ? -v : v;
  endfunction

  function automatic logic [POS_W-1:0] mag(input logic signed [POS_W-1:0] v);
    mag = v[POS_W-1] ? POS_W'(-v) : POS_W'(v);
  endfunction

  assign cur_op = sps_pkg::sps_op_t'(rd_word[`SPS_OP_MSB:`SPS_OP_LSB]);
  assign cur_val = POS_W'($signed(rd_word[`SPS_VAL_MSB:0]));
  assign dir_flip = start_direction_param[`SPS_DIR_BIT];
  assign ppos = flip(axis_pos, dir_flip);
  // only forward start begins a program
  assign start_rise = forward_start_input & ~start_q;
  assign pi1_rise = program_input_one & ~pi1_q;
  assign pulse_rise = mpg_pulse & ~mpg_q;
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign mem_we = wb_req & wb_we_i & (wb_adr_i == `SPS_REG_PROG_DATA) & (wb_sel_i == 4'hf);
  assign prog_busy = (state != sps_pkg::SPS_IDLE);

  sps_prog_mem #(
    .AW(AW),
    .DW(32)
  ) u_mem (
    .clk(clk),
    .wr_en(mem_we),
    .wr_addr(load_addr),
    .wr_data(wb_dat_i),
    .rd_addr({prog, step}),
    .rd_data(rd_word)
  );

  // Wishbone slave: one wait state, unmapped reads zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          `SPS_REG_CMD_MODE: wb_dat_o <= {28'h0, command_mode_param};
          `SPS_REG_START_DIR: wb_dat_o <= {28'h0, start_direction_param};
          `SPS_REG_PROG_ADDR: wb_dat_o <= 32'(load_addr);
          `SPS_REG_STATUS: wb_dat_o <= 32'({axis_fast_decel, mode_err, prog_busy, 1'b0,
                                           state, 3'b0, step} & 15'h7fff);
          `SPS_REG_PULSE_CNT: wb_dat_o <= pulse_cnt;
          `SPS_REG_LOOP_INFO: wb_dat_o <= {4'h0, loop_left};
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      command_mode_param <= `SPS_CMD_MODE_RST;
      start_direction_param <= `SPS_START_DIR_RST;
      load_addr <= '0;
    end else if (wb_req && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == `SPS_REG_CMD_MODE) begin
        command_mode_param <= wb_dat_i[3:0];
      end
      if (wb_adr_i == `SPS_REG_START_DIR) begin
        start_direction_param <= wb_dat_i[3:0];
      end
      if (wb_adr_i == `SPS_REG_PROG_ADDR) begin
        load_addr <= wb_dat_i[AW-1:0];
      end
      if (mem_we) begin
        load_addr <= load_addr + 1'b1;
      end
    end
  end

  // Mode error: set wins over software clear
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_err <= 1'b0;
    end else if (state == sps_pkg::SPS_IDLE && start_rise &&
                 command_mode_param != `SPS_CMD_MODE_ABS) begin
      mode_err <= 1'b1;
    end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `SPS_REG_CTRL &&
                 wb_dat_i[`SPS_CTRL_CLR_ERR]) begin
      mode_err <= 1'b0;
    end
  end

  // Input edge history
  always_ff @(posedge clk) begin
    if (!rstn) begin
      start_q <= 1'b0;
      pi1_q <= 1'b0;
      mpg_q <= 1'b0;
      pi1_pos <= '0;
    end else begin
      start_q <= forward_start_input;
      pi1_q <= program_input_one;
      mpg_q <= mpg_pulse;
      // latch live position at input edge
      if (pi1_rise) begin
        pi1_pos <= ppos;
      end
    end
  end

  // clear wins but a same-cycle pulse still counts
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pulse_cnt <= 32'h0;
    end else if (cnt_clr) begin
      pulse_cnt <= {31'h0, pulse_rise};
    end else if (pulse_rise) begin
      pulse_cnt <= pulse_cnt + 32'h1;
    end
  end

  assign cnt_clr = (state == sps_pkg::SPS_DECODE) && (cur_op == sps_pkg::SPS_OP_COUNT) &&
                   (cur_val == '0);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= sps_pkg::SPS_IDLE;
      prog <= '0;
      step <= '0;
      loop_start <= '0;
      loop_left <= '0;
      rep_en <= 1'b0;
      rep_endless <= 1'b0;
      rep_left <= '0;
      arg <= '0;
      cmd_end <= '0;
      move_start <= '0;
      last_dist <= '0;
      last_neg <= 1'b0;
      wait_done <= 1'b0;
      axis_cmd_valid <= 1'b0;
      axis_cmd_kind <= sps_pkg::SPS_AX_MOVE;
      axis_cmd_target <= '0;
      axis_fast_decel <= 1'b0;
    end else begin
      unique case (state)
        sps_pkg::SPS_IDLE: begin
          // forward start loads the selected program
          if (start_rise && command_mode_param == `SPS_CMD_MODE_ABS) begin
            prog <= prog_select;
            step <= '0;
            rep_en <= 1'b0;
            loop_left <= '0;
            cmd_end <= ppos;
            last_dist <= '0;
            state <= sps_pkg::SPS_FETCH;
          end
        end
        sps_pkg::SPS_FETCH: begin
          state <= sps_pkg::SPS_DECODE;
        end
        sps_pkg::SPS_DECODE: begin
          arg <= cur_val;
          // next step in order by default
          step <= step + 1'b1;
          state <= sps_pkg::SPS_FETCH;
          unique case (cur_op)
            sps_pkg::SPS_OP_END: begin
              // rerun from the step after the repeat
              if (rep_en && (rep_endless || rep_left > 28'h1)) begin
                if (!rep_endless) begin
                  rep_left <= rep_left - 28'h1;
                end
                step <= STEP_W'(1);
              end else begin
                state <= sps_pkg::SPS_IDLE;
              end
            end
            sps_pkg::SPS_OP_TIMES: begin
              if (step == '0) begin
                rep_en <= 1'b1;
                rep_endless <= (cur_val == '0);
                rep_left <= cur_val[27:0];
              end
            end
            sps_pkg::SPS_OP_FOR: begin
              loop_start <= step + 1'b1;
              loop_left <= cur_val[27:0];
            end
            sps_pkg::SPS_OP_NEXT: begin
              if (loop_left > 28'h1) begin
                loop_left <= loop_left - 28'h1;
                step <= loop_start;
              end else begin
                loop_left <= '0;
              end
            end
            sps_pkg::SPS_OP_MOVE_ABS, sps_pkg::SPS_OP_MOVE_INC,
            sps_pkg::SPS_OP_MOVE_ABS_CONT, sps_pkg::SPS_OP_MOVE_INC_CONT: begin
              logic signed [POS_W-1:0] tgt;
              tgt = (cur_op == sps_pkg::SPS_OP_MOVE_INC ||
                     cur_op == sps_pkg::SPS_OP_MOVE_INC_CONT) ? cmd_end + cur_val : cur_val;
              cmd_end <= tgt;
              move_start <= cmd_end;
              last_dist <= mag(tgt - cmd_end);
              last_neg <= (tgt < cmd_end);
              axis_cmd_target <= flip(tgt, dir_flip);
              axis_cmd_kind <= (cur_op == sps_pkg::SPS_OP_MOVE_ABS ||
                                cur_op == sps_pkg::SPS_OP_MOVE_INC) ?
                               sps_pkg::SPS_AX_MOVE : sps_pkg::SPS_AX_MOVE_CONT;
              wait_done <= (cur_op == sps_pkg::SPS_OP_MOVE_ABS ||
                            cur_op == sps_pkg::SPS_OP_MOVE_INC);
              axis_cmd_valid <= 1'b1;
              step <= step;
              state <= sps_pkg::SPS_ISSUE;
            end
            sps_pkg::SPS_OP_ITP: begin
              // skip when prior move is shorter
              if (last_dist >= mag(cur_val)) begin
                logic signed [POS_W-1:0] stop_at;
                // stop distance counted from the input edge
                stop_at = last_neg ? pi1_pos - cur_val : pi1_pos + cur_val;
                cmd_end <= stop_at;
                axis_cmd_target <= flip(stop_at, dir_flip);
                axis_cmd_kind <= sps_pkg::SPS_AX_ITP;
                // too short to brake at set rate
                axis_fast_decel <= (mag(cur_val) < axis_decel_dist);
                wait_done <= 1'b1;
                axis_cmd_valid <= 1'b1;
                step <= step;
                state <= sps_pkg::SPS_ISSUE;
              end
            end
            sps_pkg::SPS_OP_WAIT_IN: begin
              step <= step;
              state <= sps_pkg::SPS_WAIT_IN;
            end
            sps_pkg::SPS_OP_COUNT: begin
              if (cur_val != '0) begin
                step <= step;
                state <= sps_pkg::SPS_WAIT_CNT;
              end
            end
            sps_pkg::SPS_OP_TRIP_ABS, sps_pkg::SPS_OP_TRIP_INC: begin
              wait_done <= (cur_op == sps_pkg::SPS_OP_TRIP_INC);
              step <= step;
              state <= sps_pkg::SPS_WAIT_TRIP;
            end
            // Unknown codes are stepped over, never stall the axis
            default: begin
            end
          endcase
        end
        sps_pkg::SPS_ISSUE: begin
          if (axis_cmd_ready) begin
            axis_cmd_valid <= 1'b0;
            if (wait_done) begin
              state <= sps_pkg::SPS_MOVE_WAIT;
            end else begin
              step <= step + 1'b1;
              state <= sps_pkg::SPS_FETCH;
            end
          end
        end
        sps_pkg::SPS_MOVE_WAIT: begin
          if (axis_done) begin
            axis_fast_decel <= 1'b0;
            step <= step + 1'b1;
            state <= sps_pkg::SPS_FETCH;
          end
        end
        sps_pkg::SPS_WAIT_IN: begin
          // hold until input one is on
          if (program_input_one) begin
            step <= step + 1'b1;
            state <= sps_pkg::SPS_FETCH;
          end
        end
        sps_pkg::SPS_WAIT_CNT: begin
          if ($signed({1'b0, pulse_cnt}) > 33'(arg)) begin
            step <= step + 1'b1;
            state <= sps_pkg::SPS_FETCH;
          end
        end
        sps_pkg::SPS_WAIT_TRIP: begin
          if (wait_done ? (mag(ppos - move_start) >= mag(arg)) :
              (last_neg ? (ppos <= arg) : (ppos >= arg))) begin
            step <= step + 1'b1;
            state <= sps_pkg::SPS_FETCH;
          end
        end
      endcase
    end
  end

endmodule

// File: sps_defs.svh
`ifndef SPS_DEFS_SVH
`define SPS_DEFS_SVH

// Register byte offsets
`define SPS_REG_CTRL 8'h00
`define SPS_REG_CMD_MODE 8'h04
`define SPS_REG_START_DIR 8'h08
`define SPS_REG_PROG_ADDR 8'h0c
`define SPS_REG_PROG_DATA 8'h10
`define SPS_REG_STATUS 8'h14
`define SPS_REG_PULSE_CNT 8'h18
`define SPS_REG_LOOP_INFO 8'h1c

// Reset values and the absolute command mode code
`define SPS_CMD_MODE_RST 4'h0
`define SPS_START_DIR_RST 4'h0
`define SPS_CMD_MODE_ABS 4'h0

// Field positions
`define SPS_CTRL_CLR_ERR 0
`define SPS_DIR_BIT 0
`define SPS_OP_MSB 31
`define SPS_OP_LSB 28
`define SPS_VAL_MSB 27
`define SPS_ST_STEP_LSB 0
`define SPS_ST_STATE_LSB 8
`define SPS_ST_BUSY 12
`define SPS_ST_MODE_ERR 13
`define SPS_ST_FAST_DECEL 14

`endif

// File: sps_pkg.sv
package sps_pkg;

  typedef enum logic [3:0] {
    SPS_OP_END = 4'h0,
    SPS_OP_MOVE_ABS = 4'h1,
    SPS_OP_MOVE_INC = 4'h2,
    SPS_OP_MOVE_ABS_CONT = 4'h3,
    SPS_OP_MOVE_INC_CONT = 4'h4,
    SPS_OP_WAIT_IN = 4'h5,
    SPS_OP_ITP = 4'h6,
    SPS_OP_COUNT = 4'h7,
    SPS_OP_FOR = 4'h8,
    SPS_OP_NEXT = 4'h9,
    SPS_OP_TIMES = 4'ha,
    SPS_OP_TRIP_ABS = 4'hb,
    SPS_OP_TRIP_INC = 4'hc
  } sps_op_t;

  typedef enum logic [1:0] {
    SPS_AX_MOVE = 2'h0,
    SPS_AX_MOVE_CONT = 2'h1,
    SPS_AX_ITP = 2'h2
  } sps_axis_kind_t;

  typedef enum logic [2:0] {
    SPS_IDLE = 3'b000,
    SPS_FETCH = 3'b001,
    SPS_DECODE = 3'b011,
    SPS_ISSUE = 3'b010,
    SPS_MOVE_WAIT = 3'b110,
    SPS_WAIT_IN = 3'b111,
    SPS_WAIT_CNT = 3'b101,
    SPS_WAIT_TRIP = 3'b100
  } sps_state_t;

endpackage

// File: sps_prog_mem.sv
`timescale 1ns/1ps
module sps_prog_mem #(
  parameter int AW = 8,
  parameter int DW = 32
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read keeps the decode path short
  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end

endmodule

// File: sps_axis_model.sv
`timescale 1ns/1ps
module sps_axis_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_kind,
  input wire logic signed [31:0] cmd_target,
  output logic cmd_ready,
  output logic done,
  output logic signed [31:0] pos
);
  logic busy;
  logic tick;
  logic [3:0] cnt;
  logic [1:0] kind;
  logic signed [31:0] tgt;
  // Slow axis listens only on alternate cycles
  assign cmd_ready = !busy && (!slow || tick);
  always_ff @(posedge clk) begin
    tick <= !tick;
    done <= 1'b0;
    if (!rstn) begin
      busy <= 1'b0;
      tick <= 1'b0;
      pos <= 32'sh0;
    end else if (cmd_valid && cmd_ready) begin
      busy <= 1'b1;
      cnt <= slow ? 4'h9 : 4'h1;
      kind <= cmd_kind;
      tgt <= cmd_target;
    end else if (busy && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (busy) begin
      busy <= 1'b0;
      pos <= tgt;
      done <= (kind != 2'h1);
    end
  end
endmodule

// File: sps_seq_chk.sv
`timescale 1ns/1ps
module sps_seq_chk #(
  parameter int POS_W = 32
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic forward_start_input,
  input wire logic axis_done,
  input wire logic axis_cmd_ready,
  input wire logic axis_cmd_valid,
  input wire logic [1:0] axis_cmd_kind,
  input wire logic signed [POS_W-1:0] axis_cmd_target,
  input wire logic prog_busy
);
  logic in_flight;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Waiting moves block the next issue until arrival
  always_ff @(posedge clk) begin
    if (!rstn || axis_done) begin
      in_flight <= 1'b0;
    end else if (axis_cmd_valid && axis_cmd_ready && axis_cmd_kind != 2'h1) begin
      in_flight <= 1'b1;
    end
  end
  a_reset_quiet: assert property (disable iff (1'b0)
    !rstn |=> !prog_busy && !axis_cmd_valid && !wb_ack_o) else $error("active after reset");
  a_hold_cmd: assert property (
    axis_cmd_valid && !axis_cmd_ready |=> axis_cmd_valid && $stable(axis_cmd_target)
    && $stable(axis_cmd_kind)) else $error("command changed before acceptance");
  a_drop_cmd: assert property (
    axis_cmd_valid && axis_cmd_ready |=> !axis_cmd_valid) else $error("valid held after accept");
  a_one_flight: assert property (
    in_flight |-> !axis_cmd_valid) else $error("second command before arrival");
  a_busy_cmd: assert property (
    axis_cmd_valid |-> prog_busy) else $error("command while idle");
  a_no_start: assert property (
    !prog_busy && !forward_start_input && !$past(forward_start_input) |=> !prog_busy)
    else $error("program began without start");
  a_ack_next: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("bus ack late");
  a_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("bus ack longer than one cycle");
  a_unmapped_read: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i > 8'h1c |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  c_itp: cover property (axis_cmd_valid && axis_cmd_ready && axis_cmd_kind == 2'h2);
  c_wait: cover property (in_flight && axis_done);
  c_write: cover property (wb_ack_o && wb_we_i);
endmodule
bind sps_sequencer sps_seq_chk #(.POS_W(POS_W)) u_chk (.clk, .rstn, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .forward_start_input, .axis_done,
  .axis_cmd_ready, .axis_cmd_valid, .axis_cmd_kind, .axis_cmd_target, .prog_busy);

// File: servo_program_step_sequencer_test.sv
`timescale 1ns/1ps
`include "sps_defs.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module servo_program_step_sequencer_test;
  localparam sps_pkg::sps_op_t o_end = sps_pkg::SPS_OP_END, o_abs = sps_pkg::SPS_OP_MOVE_ABS,
    o_inc = sps_pkg::SPS_OP_MOVE_INC, o_win = sps_pkg::SPS_OP_WAIT_IN,
    o_itp = sps_pkg::SPS_OP_ITP, o_cnt = sps_pkg::SPS_OP_COUNT, o_for = sps_pkg::SPS_OP_FOR,
    o_nxt = sps_pkg::SPS_OP_NEXT, o_tim = sps_pkg::SPS_OP_TIMES,
    o_mac = sps_pkg::SPS_OP_MOVE_ABS_CONT, o_icn = sps_pkg::SPS_OP_MOVE_INC_CONT,
    o_tra = sps_pkg::SPS_OP_TRIP_ABS, o_tri = sps_pkg::SPS_OP_TRIP_INC;
  logic clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, fwd = 0, rev = 0, pin = 0, mpg = 0;
  logic slow = 0, itp_fast = 0;
  logic [7:0] adr = 8'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, dcl = 32'h0, rd, dat_o;
  logic [2:0] psel = 3'h0;
  logic ack, ready, done, valid, fast, busy;
  logic [1:0] kind;
  logic signed [31:0] pos, tgt;
  logic [33:0] q[$];
  int errors = 0, comparisons = 0, cycles = 0;
  sps_sequencer i_dut (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .forward_start_input(fwd), .reverse_start_input(rev), .prog_select(psel),
    .program_input_one(pin), .mpg_pulse(mpg), .axis_pos(pos), .axis_decel_dist(dcl),
    .axis_done(done), .axis_cmd_ready(ready), .axis_cmd_valid(valid), .axis_cmd_kind(kind),
    .axis_cmd_target(tgt), .axis_fast_decel(fast), .prog_busy(busy));
  sps_axis_model i_axis (.clk(clk), .rstn(rstn), .slow(slow), .cmd_valid(valid),
    .cmd_kind(kind), .cmd_target(tgt), .cmd_ready(ready), .done(done), .pos(pos));
  always #25 clk = ~clk;
  // Sampled mid-cycle so the queue never races the main sequence
  always @(negedge clk) begin
    cycles++;
    if (valid && ready) q.push_back({kind, tgt});
    if (valid && ready && kind == 2'h2) itp_fast = fast;
    if (cycles == 10000) begin
      errors++;
      results();
    end
  end
  task automatic results();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [31:0] pw(input sps_pkg::sps_op_t o, input logic [27:0] v);
    return {o, v};
  endfunction
  task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do @(posedge clk); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic load(input logic [2:0] n, input logic [31:0] w[$]);
    wbx(1'b1, `SPS_REG_PROG_ADDR, {24'h0, n, 5'h0});
    foreach (w[i]) wbx(1'b1, `SPS_REG_PROG_DATA, w[i]);
  endtask
  task automatic run(input logic [2:0] n);
    @(posedge clk);
    psel <= n;
    fwd <= 1'b1;
    repeat (4) @(posedge clk);
    fwd <= 1'b0;
  endtask
  task automatic idle();
    do @(posedge clk); while (busy !== 1'b0);
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk);
      mpg <= 1'b1;
      @(posedge clk);
      mpg <= 1'b0;
    end
  endtask
  task automatic mv(input logic [1:0] k, input logic [31:0] t);
    logic [33:0] e;
    while (q.size() == 0) @(posedge clk);
    e = q.pop_front();
    `CHK("axis_cmd", {k, t}, e)
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    wbx(1'b0, `SPS_REG_CMD_MODE, 32'h0);
    `CHK("cmd_mode", 32'h0, rd)
    wbx(1'b0, `SPS_REG_START_DIR, 32'h0);
    `CHK("start_dir", 32'h0, rd)
    wbx(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    rev <= 1'b1;
    repeat (4) @(negedge clk);
    `CHK("rev_busy", 1'b0, busy)
    @(posedge clk);
    rev <= 1'b0;
    load(3'h0, '{pw(o_abs, 28'h64), pw(o_inc, 28'h14), pw(o_end, 28'h0)});
    run(3'h0);
    mv(2'h0, 32'h64);
    mv(2'h0, 32'h78);
    idle();
    wbx(1'b1, `SPS_REG_CMD_MODE, 32'h1);
    run(3'h0);
    @(negedge clk);
    `CHK("mode_busy", 1'b0, busy)
    wbx(1'b0, `SPS_REG_STATUS, 32'h0);
    `CHK("mode_err", 1'b1, rd[`SPS_ST_MODE_ERR])
    wbx(1'b1, `SPS_REG_CMD_MODE, 32'h0);
    wbx(1'b1, `SPS_REG_CTRL, 32'h1);
    wbx(1'b0, `SPS_REG_STATUS, 32'h0);
    `CHK("err_clear", 1'b0, rd[`SPS_ST_MODE_ERR])
    load(3'h1, '{pw(o_for, 28'h3), pw(o_inc, 28'ha), pw(o_nxt, 28'h0), pw(o_end, 28'h0)});
    load(3'h2, '{pw(o_tim, 28'h2), pw(o_inc, 28'h5), pw(o_end, 28'h0)});
    run(3'h1);
    for (int i = 1; i <= 3; i++) mv(2'h0, 32'h78 + 32'(i) * 32'ha);
    idle();
    run(3'h2);
    mv(2'h0, 32'h9b);
    mv(2'h0, 32'ha0);
    idle();
    `CHK("extra_moves", 32'h0, 32'(q.size()))
    load(3'h3, '{pw(o_tim, 28'h0), pw(o_abs, 28'h7), pw(o_end, 28'h0)});
    run(3'h3);
    repeat (3) mv(2'h0, 32'h7);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    q.delete();
    load(3'h4, '{pw(o_win, 28'h1), pw(o_abs, 28'h32), pw(o_end, 28'h0)});
    run(3'h4);
    repeat (10) @(posedge clk);
    `CHK("input_held", 32'h0, 32'(q.size()))
    pin <= 1'b1;
    mv(2'h0, 32'h32);
    idle();
    pin <= 1'b0;
    pulse(2);
    load(3'h5, '{pw(o_cnt, 28'h0), pw(o_cnt, 28'h3), pw(o_abs, 28'h3c), pw(o_end, 28'h0)});
    run(3'h5);
    pulse(3);
    repeat (5) @(posedge clk);
    `CHK("count_held", 32'h0, 32'(q.size()))
    pulse(1);
    mv(2'h0, 32'h3c);
    idle();
    wbx(1'b0, `SPS_REG_PULSE_CNT, 32'h0);
    `CHK("pulse_cnt", 32'h4, rd)
    // Slow axis here to stretch every handshake
    dcl <= 32'h1f4;
    slow <= 1'b1;
    // Input one rises mid-move, so the stop counts from the latched spot
    load(3'h6, '{pw(o_mac, 28'h3e8), pw(o_win, 28'h1), pw(o_itp, 28'hc8),
      pw(o_end, 28'h0)});
    run(3'h6);
    mv(2'h1, 32'h3e8);
    pin <= 1'b1;
    mv(2'h2, 32'h104);
    `CHK("fast_decel", 1'b1, itp_fast)
    idle();
    pin <= 1'b0;
    slow <= 1'b0;
    load(3'h7, '{pw(o_inc, 28'h64), pw(o_win, 28'h1), pw(o_itp, 28'hc8), pw(o_abs, 28'h3),
      pw(o_end, 28'h0)});
    run(3'h7);
    mv(2'h0, 32'h168);
    repeat (20) @(posedge clk);
    pin <= 1'b1;
    mv(2'h0, 32'h3);
    idle();
    pin <= 1'b0;
    load(3'h4, '{pw(o_icn, 28'h40), pw(o_tri, 28'h30), pw(o_tra, 28'h40), pw(o_abs, 28'h8),
      pw(o_end, 28'h0)});
    run(3'h4);
    mv(2'h1, 32'h43);
    mv(2'h0, 32'h8);
    idle();
    wbx(1'b1, `SPS_REG_START_DIR, 32'h1);
    run(3'h0);
    mv(2'h0, -32'sh64);
    mv(2'h0, -32'sh78);
    idle();
    results();
  end
endmodule
